// ==== rtl/fwx_defs.svh ====
// Shared constants for the cascadable FIFO slice and its system logic
`ifndef FWX_DEFS_SVH
`define FWX_DEFS_SVH

// ----------------------------------------------------------------
// Word and buffer geometry
// ----------------------------------------------------------------
`define FWX_W        18
`define FWX_DEPTH    32
`define FWX_AW       5
`define FWX_LW       6
`define FWX_NDEV     2

// ----------------------------------------------------------------
// Occupancy levels and flag offsets
// ----------------------------------------------------------------
`define FWX_LVL_FULL  6'h20
`define FWX_LVL_LAST  6'h1F
`define FWX_LVL_ONE   6'h01
`define FWX_LVL_ZERO  6'h00
`define FWX_LVL_HALF  6'h10
`define FWX_OFS_W     16
`define FWX_OFS_DEF   16'h007F
`define FWX_CMP_W     17
`define FWX_CMP_FULL  17'h0_0020

`endif

// ==== rtl/fwx_pkg.sv ====
// Types shared by the FIFO slice and the system logic
package fwx_pkg;
   // Which offset register the next offset write lands in
   typedef enum logic {FWX_OFS_EMPTY, FWX_OFS_FULL} fwx_ofs_sel_t;
   // Token start-up: catch the first-device strap, then run
   typedef enum logic {FWX_ST_STRAP, FWX_ST_RUN} fwx_tok_st_t;
endpackage

// ==== rtl/fwx_if.sv ====
// Pin bundle joining the system logic to a chain of FIFO slices
`timescale 1ns/1ps
`include "fwx_defs.svh"
interface fwx_if #(parameter int NDEV = `FWX_NDEV);
   wire                   depth_mode;
   wire                   wr_en_n;
   wire                   rd_en_n;
   wire                   out_en_n;
   wire                   offset_load_sel_n;
   wire                   replay_request;
   wire [NDEV*`FWX_W-1:0] d;
   wire [NDEV*`FWX_W-1:0] q;
   wire [NDEV-1:0]        q_oe;
   wire [NDEV-1:0]        first_device_select_n;
   wire [NDEV-1:0]        empty_indicator_n;
   wire [NDEV-1:0]        full_indicator_n;
   wire [NDEV-1:0]        almost_empty_indicator_n;
   wire [NDEV-1:0]        almost_full_indicator_n;
   wire [NDEV-1:0]        half_occupancy_indicator_n;
   wire [NDEV-1:0]        write_token_out;
   wire [NDEV-1:0]        write_token_in;
   wire [NDEV-1:0]        read_token_out;
   wire [NDEV-1:0]        read_token_in;

   // ----------------------------------------------------------------
   // Token ring, each slice feeds the next, the last feeds the first
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NDEV; i++) begin : g_ring
      assign write_token_in[i] = write_token_out[(i + NDEV - 1) % NDEV];
      assign read_token_in[i]  = read_token_out[(i + NDEV - 1) % NDEV];
   end

   modport dev (
      input  depth_mode, wr_en_n, rd_en_n, out_en_n, offset_load_sel_n,
      input  replay_request, d, first_device_select_n,
      input  write_token_in, read_token_in,
      output q, q_oe, empty_indicator_n, full_indicator_n,
      output almost_empty_indicator_n, almost_full_indicator_n,
      output half_occupancy_indicator_n, write_token_out, read_token_out
   );
   modport sys (
      output depth_mode, wr_en_n, rd_en_n, out_en_n, offset_load_sel_n,
      output replay_request, d, first_device_select_n,
      input  q, q_oe, empty_indicator_n, full_indicator_n,
      input  almost_empty_indicator_n, almost_full_indicator_n,
      input  half_occupancy_indicator_n
   );
endinterface // fwx_if

// ==== rtl/fwx_buf.sv ====
// Parameterised ring buffer with valid/ready on both sides and rewind
`timescale 1ns/1ps
`include "fwx_defs.svh"
module fwx_buf
   import fwx_pkg::*;
#(
   parameter int WIDTH = `FWX_W,
   parameter int DEPTH = `FWX_DEPTH
) (
   input  wire logic                     sys_clk_i,   // System clock
   input  wire logic                     nrst_i,      // Async reset, low
   input  wire logic                     in_valid_i,  // Write offered
   output      logic                     in_ready_o,  // Room for a word
   input  wire logic [WIDTH-1:0]         in_data_i,   // Write word
   output      logic                     out_valid_o, // Word available
   input  wire logic                     out_ready_i, // Reader takes it
   output      logic [WIDTH-1:0]         out_data_o,  // Head word
   input  wire logic                     rewind_i,    // Read ptr to start
   output      logic [$clog2(DEPTH):0]   level_o      // Words held
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      level;
   logic             wrapped;
   logic             push;
   logic             pop;

   // ----------------------------------------------------------------
   // Handshake decode
   // ----------------------------------------------------------------
   assign in_ready_o  = level != DEPTH[AW:0];
   assign out_valid_o = level != '0;
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i && !rewind_i;
   assign out_data_o  = mem[rd_ptr];
   assign level_o     = level;

   // Storage array, written on accepted pushes
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and level; rewind replays from the first location
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         level   <= '0;
         wrapped <= 1'h0;
      end else begin
         if (push) begin
            wr_ptr  <= wr_ptr + 1'b1;
            wrapped <= wrapped || (wr_ptr == AW'(DEPTH - 1));
         end
         if (rewind_i) begin
            rd_ptr <= '0;
            level  <= wrapped ? DEPTH[AW:0] : {1'b0, wr_ptr};
         end else begin
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            level  <= level + (AW+1)'(push) - (AW+1)'(pop);
         end
      end
   end
endmodule // fwx_buf

// ==== rtl/fwx_slice.sv ====
// One 18-bit FIFO slice with cascade tokens, flags and offset loading
`timescale 1ns/1ps
`include "fwx_defs.svh"

// Operation
// - Wide words are whole 18-bit slices
// - Controls shared by all slices, flags kept
// - System ANDs empty and full indicators
// - Almost flags taken from one slice
// - System gates access with combined flags
// - Both almost offsets default to 127
// - Low first-select marks the first slice
// - Write token out feeds next slice
// - Read token out feeds next slice
// - Offset load select common to all
// - Half flag unused in depth chains
// - System ORs flags in depth chains
// - Composite almost flags are approximate
// - Full and empty indicators active low
// - Only read owner drives shared output; here the slice that served the last read drives until the next read
// - Replay ignored in depth chains
module fwx_slice
   import fwx_pkg::*;
#(
   parameter int NDEV = `FWX_NDEV,
   parameter int SLOT = 0
) (
   input  wire logic sys_clk_i,  // System clock
   input  wire logic nrst_i,     // Async reset, active low
   fwx_if.dev        pins        // Slice pins in the chain
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [`FWX_W-1:0]     d_slice;
   logic [`FWX_W-1:0]     head;
   logic [`FWX_W-1:0]     q;
   logic [`FWX_LW-1:0]    level;
   logic [`FWX_OFS_W-1:0] ae_ofs;
   logic [`FWX_OFS_W-1:0] af_ofs;
   logic [`FWX_CMP_W-1:0] af_sum;
   logic [`FWX_AW-1:0]    wr_cnt;
   logic [`FWX_AW-1:0]    rd_cnt;
   logic                  q_own;
   logic                  q_lose;
   fwx_ofs_sel_t          ofs_sel;
   fwx_ofs_sel_t          next_ofs_sel;
   fwx_tok_st_t           tok_st;
   logic                  wtok;
   logic                  rtok;
   logic                  next_wtok;
   logic                  next_rtok;
   logic                  wtok_pulse;
   logic                  rtok_pulse;
   logic                  deep;
   logic                  ld_active;
   logic                  wr_req;
   logic                  rd_req;
   logic                  wr_own;
   logic                  rd_own;
   logic                  buf_in_valid;
   logic                  buf_in_ready;
   logic                  buf_out_valid;
   logic                  buf_out_ready;
   logic                  wr_fire;
   logic                  rd_fire;
   logic                  ofs_wr;
   logic                  fill;
   logic                  drain;
   logic                  rewind;

   // ----------------------------------------------------------------
   // Pin decode
   // ----------------------------------------------------------------
   // this slice owns one 18-bit lane
   assign d_slice   = pins.d[SLOT*`FWX_W +: `FWX_W];
   assign deep      = pins.depth_mode;
   assign ld_active = !pins.offset_load_sel_n;
   assign wr_req    = !pins.wr_en_n;
   assign rd_req    = !pins.rd_en_n && !ld_active;

   assign wr_own = !deep || wtok || pins.write_token_in[SLOT];
   assign rd_own = !deep || rtok || pins.read_token_in[SLOT];

   // Access qualification against buffer state
   assign buf_in_valid  = wr_req && !ld_active && wr_own;
   assign buf_out_ready = rd_req && rd_own;
   assign wr_fire       = buf_in_valid && buf_in_ready;
   assign rd_fire       = buf_out_valid && buf_out_ready;
   assign ofs_wr        = wr_req && ld_active;

   assign rewind = pins.replay_request && !deep;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   fwx_buf #(
      .WIDTH (`FWX_W),
      .DEPTH (`FWX_DEPTH)
   ) u_buf (
      .sys_clk_i   (sys_clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (buf_in_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (d_slice),
      .out_valid_o (buf_out_valid),
      .out_ready_i (buf_out_ready),
      .out_data_o  (head),
      .rewind_i    (rewind),
      .level_o     (level)
   );

   // ----------------------------------------------------------------
   // Output register and shared bus drive
   // ----------------------------------------------------------------
   // Another slice serves this read, so give up the shared bus
   assign q_lose = deep && rd_req && !rd_own;

   // Output word, held over empty reads; bus claim follows the server
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q     <= '0;
         q_own <= 1'h0;
      end else begin
         if (rd_fire) begin
            q <= head;
         end
         q_own <= rd_fire || (q_own && !q_lose);
      end
   end

   // in deep chains only the slice that served the last read drives; wide slices all drive
   assign pins.q[SLOT*`FWX_W +: `FWX_W] = q;
   assign pins.q_oe[SLOT] = !pins.out_en_n && (!deep || q_own);

   // ----------------------------------------------------------------
   // Offset registers
   // ----------------------------------------------------------------
   // Alternate empty and full offset on each load write
   assign next_ofs_sel = (ofs_sel == FWX_OFS_EMPTY) ? FWX_OFS_FULL
                                                    : FWX_OFS_EMPTY;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ae_ofs  <= `FWX_OFS_DEF;
         af_ofs  <= `FWX_OFS_DEF;
         ofs_sel <= FWX_OFS_EMPTY;
      end else if (ofs_wr) begin
         ofs_sel <= next_ofs_sel;
         if (ofs_sel == FWX_OFS_EMPTY) begin
            ae_ofs <= d_slice[`FWX_OFS_W-1:0];
         end else begin
            af_ofs <= d_slice[`FWX_OFS_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Status flags, all active low
   // ----------------------------------------------------------------
   // Almost-full compare in a wide field so large offsets never wrap
   assign af_sum = `FWX_CMP_W'(level) + `FWX_CMP_W'(af_ofs);

   assign pins.full_indicator_n[SLOT]  = level != `FWX_LVL_FULL;
   assign pins.empty_indicator_n[SLOT] = level != `FWX_LVL_ZERO;
   assign pins.almost_empty_indicator_n[SLOT] =
      `FWX_OFS_W'(level) > ae_ofs;
   assign pins.almost_full_indicator_n[SLOT] = af_sum < `FWX_CMP_FULL;
   // half flag parked high when deep
   assign pins.half_occupancy_indicator_n[SLOT] =
      deep || !(level > `FWX_LVL_HALF);

   // ----------------------------------------------------------------
   // Cascade tokens
   // ----------------------------------------------------------------
   // Location counters mirror the buffer pointers in deep chains
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_cnt <= '0;
         rd_cnt <= '0;
      end else begin
         wr_cnt <= wr_cnt + `FWX_AW'(wr_fire);
         rd_cnt <= rd_cnt + `FWX_AW'(rd_fire);
      end
   end

   // hand write token on the write that fills the last location
   assign fill  = deep && wr_fire && ({1'b0, wr_cnt} == `FWX_LVL_LAST);
   // hand read token on the read that empties the last location
   assign drain = deep && rd_fire && ({1'b0, rd_cnt} == `FWX_LVL_LAST);

   // Token next values; an arriving token is kept unless spent now
   assign next_wtok = (wtok || pins.write_token_in[SLOT]) && !fill;
   assign next_rtok = (rtok || pins.read_token_in[SLOT]) && !drain;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tok_st <= FWX_ST_STRAP;
         wtok   <= 1'h0;
         rtok   <= 1'h0;
      end else begin
         unique case (tok_st)
            FWX_ST_STRAP: begin
               wtok   <= !pins.first_device_select_n[SLOT];
               rtok   <= !pins.first_device_select_n[SLOT];
               tok_st <= FWX_ST_RUN;
            end
            FWX_ST_RUN: begin
               wtok <= next_wtok;
               rtok <= next_rtok;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wtok_pulse <= 1'h0;
         rtok_pulse <= 1'h0;
      end else begin
         wtok_pulse <= fill;
         rtok_pulse <= drain;
      end
   end

   assign pins.write_token_out[SLOT] = wtok_pulse;
   assign pins.read_token_out[SLOT]  = rtok_pulse;
endmodule // fwx_slice

// ==== rtl/fwx_sys.sv ====
// System writer/reader logic driving a chain of FIFO slices
`timescale 1ns/1ps
`include "fwx_defs.svh"
module fwx_sys
   import fwx_pkg::*;
#(
   parameter int NDEV  = `FWX_NDEV,
   parameter int FIRST = 0
) (
   input  wire logic                   sys_clk_i,     // System clock
   input  wire logic                   nrst_i,        // Async reset, low
   input  wire logic                   depth_mode_i,  // 1 deep, 0 wide
   input  wire logic                   load_i,        // Offset load
   input  wire logic                   replay_i,      // Replay pulse
   input  wire logic                   out_enable_i,  // Output enable
   input  wire logic                   wr_valid_i,    // Write offered
   output      logic                   wr_ready_o,    // Write taken
   input  wire logic [NDEV*`FWX_W-1:0] wr_data_i,     // Write word
   input  wire logic                   rd_ready_i,    // Read request
   output      logic                   rd_valid_o,    // Read word valid
   output      logic [NDEV*`FWX_W-1:0] rd_data_o,     // Read word
   output      logic                   sys_empty_n_o, // Empty, low
   output      logic                   sys_full_n_o,  // Full, low
   output      logic                   sys_aempty_n_o,// Almost empty
   output      logic                   sys_afull_n_o, // Almost full
   output      logic                   sys_half_n_o,  // Half, wide only
   fwx_if.sys                          pins           // Chain pins
);
   logic                   rd_issue;
   logic                   rd_wait;
   logic [`FWX_W-1:0]      deep_word;
   logic [NDEV*`FWX_W-1:0] wide_word;
   logic [NDEV*`FWX_W-1:0] next_word;

   // ----------------------------------------------------------------
   // Composite flags
   // ----------------------------------------------------------------
   // AND when wide; OR when deep
   assign sys_empty_n_o = depth_mode_i ? |pins.empty_indicator_n
                                       : &pins.empty_indicator_n;
   assign sys_full_n_o  = depth_mode_i ? |pins.full_indicator_n
                                       : &pins.full_indicator_n;
   // one slice when wide; approximate OR when deep
   assign sys_aempty_n_o = depth_mode_i ? |pins.almost_empty_indicator_n
                                        : pins.almost_empty_indicator_n[0];
   assign sys_afull_n_o  = depth_mode_i ? |pins.almost_full_indicator_n
                                        : pins.almost_full_indicator_n[0];
   assign sys_half_n_o = depth_mode_i || pins.half_occupancy_indicator_n[0];

   // ----------------------------------------------------------------
   // Shared controls
   // ----------------------------------------------------------------
   // gate accesses with combined flags
   assign wr_ready_o = load_i || sys_full_n_o;
   assign rd_issue   = rd_ready_i && sys_empty_n_o && !load_i;
   assign pins.depth_mode        = depth_mode_i;
   assign pins.wr_en_n           = !(wr_valid_i && wr_ready_o);
   assign pins.rd_en_n           = !rd_issue;
   assign pins.out_en_n          = !out_enable_i;
   assign pins.offset_load_sel_n = !load_i;
   assign pins.replay_request    = replay_i;

   // ----------------------------------------------------------------
   // Per-slice lanes and straps
   // ----------------------------------------------------------------
   always_comb begin
      deep_word = '0;
      for (int i = 0; i < NDEV; i++) begin
         if (pins.q_oe[i]) begin
            deep_word = deep_word | pins.q[i*`FWX_W +: `FWX_W];
         end
      end
   end

   for (genvar i = 0; i < NDEV; i++) begin : g_lane
      // one 18-bit lane per slice; deep chains share lane zero
      assign pins.d[i*`FWX_W +: `FWX_W] = depth_mode_i
         ? wr_data_i[0 +: `FWX_W] : wr_data_i[i*`FWX_W +: `FWX_W];
      assign wide_word[i*`FWX_W +: `FWX_W] = pins.q_oe[i]
         ? pins.q[i*`FWX_W +: `FWX_W] : '0;
      // only the first slice strapped low
      assign pins.first_device_select_n[i] = (i != FIRST);
   end

   assign next_word = depth_mode_i ? (NDEV*`FWX_W)'(deep_word)
                                   : wide_word;

   // Read return: slice word a cycle after issue, captured next edge
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_wait    <= 1'h0;
         rd_valid_o <= 1'h0;
         rd_data_o  <= '0;
      end else begin
         rd_wait    <= rd_issue;
         rd_valid_o <= rd_wait;
         if (rd_wait) begin
            rd_data_o <= next_word;
         end
      end
   end
endmodule // fwx_sys

// ==== tb/fwx_props.sv ====
// Checker for the pins between the system logic and the slices
`timescale 1ns/1ps
module fwx_props #(
   parameter int NDEV = 2
) (
   input wire            sys_clk_i,                  // Clock
   input wire            nrst_i,                     // Reset, low
   input wire            depth_mode,                 // Deep chain
   input wire            wr_en_n,                    // Write, low
   input wire            rd_en_n,                    // Read, low
   input wire            out_en_n,                   // Output on, low
   input wire            offset_load_sel_n,          // Offset load
   input wire [NDEV-1:0] q_oe,                       // Output drive
   input wire [NDEV-1:0] empty_indicator_n,          // Empty, low
   input wire [NDEV-1:0] full_indicator_n,           // Full, low
   input wire [NDEV-1:0] half_occupancy_indicator_n, // Half, low
   input wire [NDEV-1:0] write_token_out,            // Write token
   input wire [NDEV-1:0] read_token_out              // Read token
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   a_read_gated: assert property (!rd_en_n |->
      (depth_mode ? |empty_indicator_n : &empty_indicator_n))
      else $error("read issued on empty");
   a_write_gated: assert property (!wr_en_n && offset_load_sel_n |->
      (depth_mode ? |full_indicator_n : &full_indicator_n))
      else $error("write issued on full");
   a_wide_lockstep: assert property (!depth_mode |->
      empty_indicator_n[0] == empty_indicator_n[NDEV-1] &&
      full_indicator_n[0] == full_indicator_n[NDEV-1])
      else $error("wide slices differ");
   // wide write lands in every slice
   a_wide_write: assert property (!depth_mode && !wr_en_n &&
      offset_load_sel_n |=> &empty_indicator_n)
      else $error("wide write lost");
   a_oe_off: assert property (out_en_n |-> q_oe == '0)
      else $error("output driven while disabled");
   // write token leaves a full slice
   a_wtok_full: assert property (
      (write_token_out & full_indicator_n) == '0)
      else $error("write token from non-full slice");
   // read token leaves an empty slice
   a_rtok_empty: assert property (
      (read_token_out & empty_indicator_n) == '0)
      else $error("read token from non-empty slice");
   // write token handover is a single pulse
   a_wtok_pulse: assert property (
      (write_token_out & $past(write_token_out)) == '0)
      else $error("write token pulse too long");
   a_half_wide: assert property (!depth_mode |->
      (~full_indicator_n & half_occupancy_indicator_n) == '0)
      else $error("full without half");
endmodule // fwx_props

// ==== tb/fwx_tb.sv ====
// Bench for the wide and deep FIFO slice chain
`timescale 1ns/1ps
`include "fwx_defs.svh"
module fwx_tb;
   logic        clk, rst_n, mode, load, replay, oe, wv, rr;
   logic [35:0] wd;
   wire         wrdy, rv, e_n, f_n, ae_n, af_n, h_n;
   wire  [35:0] rdat;
   int          failures, total_checks;

   fwx_if #(.NDEV(2)) pins ();
   fwx_sys #(.NDEV(2), .FIRST(0)) fwx_sys_inst (
      .sys_clk_i(clk), .nrst_i(rst_n), .depth_mode_i(mode),
      .load_i(load), .replay_i(replay), .out_enable_i(oe),
      .wr_valid_i(wv), .wr_ready_o(wrdy), .wr_data_i(wd),
      .rd_ready_i(rr), .rd_valid_o(rv), .rd_data_o(rdat),
      .sys_empty_n_o(e_n), .sys_full_n_o(f_n), .sys_aempty_n_o(ae_n),
      .sys_afull_n_o(af_n), .sys_half_n_o(h_n), .pins(pins));
   for (genvar i = 0; i < 2; i++) begin : g_sl
      fwx_slice #(.NDEV(2), .SLOT(i)) fwx_slice_inst (
         .sys_clk_i(clk), .nrst_i(rst_n), .pins(pins));
   end
   fwx_props #(.NDEV(2)) fwx_props_inst (
      .sys_clk_i(clk), .nrst_i(rst_n), .depth_mode(pins.depth_mode),
      .wr_en_n(pins.wr_en_n), .rd_en_n(pins.rd_en_n),
      .out_en_n(pins.out_en_n), .offset_load_sel_n(pins.offset_load_sel_n),
      .q_oe(pins.q_oe), .empty_indicator_n(pins.empty_indicator_n),
      .full_indicator_n(pins.full_indicator_n),
      .half_occupancy_indicator_n(pins.half_occupancy_indicator_n),
      .write_token_out(pins.write_token_out),
      .read_token_out(pins.read_token_out));

   // ----------------------------------------------------------------
   // Clock and shared tasks
   // ----------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   // Compare and count
   task automatic chk(string nm, logic [35:0] seen, logic [35:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic results();
      $display("Checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Reset in the given mode, output enable one cycle later
   task automatic do_reset(logic m);
      @(negedge clk);
      rst_n = 1'h0;
      mode = m;
      oe = 1'h0;
      repeat (20) @(negedge clk);
      rst_n = 1'h1;
      @(negedge clk);
      oe = 1'h1;
      @(negedge clk);
   endtask

   // Offer one word, leave valid high for back-to-back use
   task automatic push(logic [35:0] d);
      int n;
      wd = d;
      wv = 1'h1;
      n = 0;
      while (wrdy !== 1'h1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100) begin
         failures++;
         results();
      end
      @(negedge clk);
   endtask

   // One read, answer exactly two edges later
   task automatic pop(logic [35:0] exp);
      chk("empty before read", e_n, 1'h1);
      rr = 1'h1;
      @(negedge clk);
      rr = 1'h0;
      chk("early valid", rv, 1'h0);
      @(negedge clk);
      chk("read valid", rv, 1'h1);
      chk("read data", rdat, exp);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Wide: defaults, offsets, fill, drain, replay
   task automatic t_wide();
      do_reset(1'h0);
      chk("reset empty", e_n, 1'h0);
      chk("reset full", f_n, 1'h1);
      chk("reset almost empty", ae_n, 1'h0);
      for (int k = 1; k <= 32; k++) begin
         if (k == 4) begin
            load = 1'h1;
            push({18'h0_0002, 18'h0_0002});
            push({18'h0_0002, 18'h0_0002});
            load = 1'h0;
         end
         push({18'(k + 64), 18'(k)});
         chk("almost empty", ae_n, 1'(k > 3));
         chk("half", h_n, 1'(k <= 16));
         chk("full", f_n, 1'(k < 32));
         if (k > 3) chk("almost full", af_n, 1'(k < 30));
      end
      chk("refused when full", wrdy, 1'h0);
      wv = 1'h0;
      for (int k = 1; k <= 32; k++) pop({18'(k + 64), 18'(k)});
      chk("drained", e_n, 1'h0);
      replay = 1'h1;
      @(negedge clk);
      replay = 1'h0;
      @(negedge clk);
      chk("replay refills", e_n, 1'h1);
      pop({18'h0_0041, 18'h0_0001});
   endtask

   // Deep: fill both slices through tokens, drain in order
   task automatic t_deep();
      do_reset(1'h1);
      for (int k = 1; k <= 64; k++) begin
         push({18'h3_FFFF, 18'(k)});
         if (k == 40) chk("both hold", pins.empty_indicator_n, 2'h3);
      end
      chk("refused when full", wrdy, 1'h0);
      wv = 1'h0;
      chk("deep full", f_n, 1'h0);
      chk("slices full", pins.full_indicator_n, 2'h0);
      chk("deep half", h_n, 1'h1);
      chk("deep almost empty", ae_n, 1'h0);
      chk("deep almost full", af_n, 1'h0);
      for (int k = 1; k <= 64; k++) pop({18'h0_0000, 18'(k)});
      chk("deep drained", e_n, 1'h0);
      replay = 1'h1;
      @(negedge clk);
      replay = 1'h0;
      @(negedge clk);
      chk("replay ignored", e_n, 1'h0);
   endtask

   // Main sequence
   initial begin
      failures = 0;
      total_checks = 0;
      rst_n = 1'h0;
      mode = 1'h0;
      load = 1'h0;
      replay = 1'h0;
      oe = 1'h0;
      wv = 1'h0;
      rr = 1'h0;
      wd = 36'h0_0000_0000;
      t_wide();
      t_deep();
      results();
   end
endmodule // fwx_tb
